// ==== logic/align_status_regs.svh ====
// offsets, field positions, reset values and counts for the lane status block
// assumes inclusion by the package and the design modules

`ifndef ALIGN_STATUS_REGS_SVH
`define ALIGN_STATUS_REGS_SVH

// ----------------------------------------
// sizes
// ----------------------------------------
`define NUM_LANES 20
`define LANE_IDX_W 5
`define MF_LEN_W 16
`define PEND_W 4
`define INT_W 4
`define CNT_W 16
`define ADDR_W 12

// ----------------------------------------
// timing
// ----------------------------------------
`define MF_LEN_DEFAULT 16'h3fff

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFF_CTRL 12'h000
`define OFF_MF_LEN 12'h004
`define OFF_STATUS 12'h008
`define OFF_LOCKED 12'h00c
`define OFF_INT_STAT 12'h010
`define OFF_INT_MASK 12'h014
`define OFF_MIS_CNT 12'h018

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define CTRL_CHECK_EN 0
`define CTRL_REARM 1
`define CTRL_RESET 1'b1
`define STAT_ARMED 0
`define STAT_REMOTE 1
`define STAT_ALL_LOCKED 2
`define INT_MISALIGN 0
`define INT_WORD_ERR 1
`define INT_REMOTE 2
`define INT_ARMED 3

`endif

// ==== logic/align_status_pkg.sv ====
// types shared by the lane status design
// assumes the register header sits beside it

`include "align_status_regs.svh"

package align_status_pkg;

  typedef logic [`LANE_IDX_W-1:0] lane_idx_t;
  typedef logic [`NUM_LANES-1:0] lane_vec_t;

  typedef enum logic [1:0] {ALIGN_WAIT = 2'b01, ALIGN_ARMED = 2'b10} align_e;

  typedef enum logic [2:0] {T_IDLE = 3'b001, T_RUN = 3'b010, T_DRAIN = 3'b100} timer_state_e;

  typedef struct packed {
    logic seen;
    lane_idx_t id;
    logic err;
    logic mism;
  } lane_s;

  typedef struct packed {
    timer_state_e state;
    logic [`MF_LEN_W-1:0] cnt;
    logic [`PEND_W-1:0] pend;
    logic pulse;
  } timer_s;

  typedef struct packed {
    align_e align;
    lane_vec_t locked;
    logic [`NUM_LANES-1:0][`LANE_IDX_W-1:0] phys;
    logic rf;
    logic check_en;
    logic [`MF_LEN_W-1:0] mf_len;
    logic [`INT_W-1:0] int_stat;
    logic [`INT_W-1:0] int_mask;
    logic [`CNT_W-1:0] mis_cnt;
    logic [31:0] prdata;
  } top_s;

endpackage

// ==== logic/lane_marker_check.sv ====
// per physical lane marker checker: lock, lane id capture, error pulses
// assumes marker strobes come from logic on the same clock

`timescale 1ns/1ps

module lane_marker_check
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // lane inputs
  input wire logic word_sync,
  input wire logic marker_strobe,
  input wire logic marker_ok,
  input wire align_status_pkg::lane_idx_t marker_id,
  // lane results
  output logic seen,
  output align_status_pkg::lane_idx_t id,
  output logic err,
  output logic mism
);
  import align_status_pkg::*;

  lane_s s_reg;
  lane_s s_next;

  always_comb
  begin
    s_next = s_reg;
    s_next.err = marker_strobe & ~marker_ok;
    s_next.mism = marker_strobe & marker_ok & s_reg.seen & (marker_id != s_reg.id);
    if (!word_sync)
      s_next.seen = 1'b0;
    else if (marker_strobe && marker_ok)
    begin
      s_next.seen = 1'b1;
      s_next.id = marker_id;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign seen = s_reg.seen;
  assign id = s_reg.id;
  assign err = s_reg.err;
  assign mism = s_reg.mism;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  bad_word_pulse_a: assert property (marker_strobe && !marker_ok |=> err)
    else $error("malformed marker gave no error pulse");
  seen_needs_sync_a: assert property ($rose(seen) |-> $past(word_sync && marker_ok))
    else $error("lane marked seen without sync and good marker");
endmodule

// ==== logic/misalign_timer.sv ====
// delays misalignment events by one metaframe and drains queued events
// assumes the metaframe length is stable while events are pending

`timescale 1ns/1ps
`include "align_status_regs.svh"

module misalign_timer
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // control
  input wire logic clear,
  input wire logic err_event,
  input wire logic [`MF_LEN_W-1:0] mf_len_minus1,
  // result
  output logic busy,
  output logic pulse
);
  import align_status_pkg::*;

  timer_s s_reg;
  timer_s s_next;

  always_comb
  begin
    s_next = s_reg;
    s_next.pulse = 1'b0;
    unique case (s_reg.state)
      T_IDLE:
      begin
        // event cycle is the first of the metaframe
        if (err_event && mf_len_minus1 == '0)
          s_next.pulse = 1'b1;
        else if (err_event)
        begin
          s_next.cnt = mf_len_minus1 - 1'b1;
          s_next.state = T_RUN;
        end
      end
      T_RUN:
      begin
        if (err_event && s_reg.pend != '1)
          s_next.pend = s_reg.pend + 1'b1;
        if (s_reg.cnt == '0)
        begin
          s_next.pulse = 1'b1;
          s_next.state = (s_next.pend != '0) ? T_DRAIN : T_IDLE;
        end
        else
          s_next.cnt = s_reg.cnt - 1'b1;
      end
      T_DRAIN:
      begin
        s_next.pulse = 1'b1;
        if (!(err_event && s_reg.pend != '1))
          s_next.pend = s_reg.pend - 1'b1;
        if (s_next.pend == '0)
          s_next.state = T_IDLE;
      end
      default:
        s_next.state = T_IDLE;
    endcase
    if (clear)
      s_next = '{state: T_IDLE, default: '0};
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      s_reg <= '{state: T_IDLE, default: '0};
    else
      s_reg <= s_next;
  end

  assign busy = (s_reg.state != T_IDLE);
  assign pulse = s_reg.pulse;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  run_expiry_a: assert property (s_reg.state == T_RUN && s_reg.cnt == '0 && !clear |=> pulse)
    else $error("no pulse at end of metaframe wait");
  run_quiet_a: assert property (s_reg.state == T_RUN && s_reg.cnt != '0 |=> !pulse)
    else $error("pulse before metaframe wait ended");
  idle_no_pulse_a: assert property (s_reg.state == T_IDLE && !err_event |=> !pulse)
    else $error("pulse out of idle");
  idle_short_a: assert property (s_reg.state == T_IDLE && err_event && !clear &&
    mf_len_minus1 == '0 |=> pulse)
    else $error("no pulse for a one-cycle metaframe");
endmodule

// ==== logic/lane_align_status.sv ====
// receive lane alignment status: misalignment pulse, remote fault, lane map
// assumes lane inputs come from the deskew logic on the same clock
//
// Local design decisions: the placing of the registers and the APB slave port.

`timescale 1ns/1ps
`include "align_status_regs.svh"

module lane_align_status
#(
  parameter logic [`MF_LEN_W-1:0] MF_LEN_MINUS1 = `MF_LEN_DEFAULT
)
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // lane inputs, indexed by physical lane
  input wire align_status_pkg::lane_vec_t word_sync,
  input wire align_status_pkg::lane_vec_t marker_strobe,
  input wire align_status_pkg::lane_vec_t marker_ok,
  input wire logic [`NUM_LANES-1:0][`LANE_IDX_W-1:0] marker_id,
  input wire logic remote_fault_in,
  // status outputs
  output logic lane_misalign_pulse,
  output align_status_pkg::lane_vec_t lane_marker_word_error,
  output logic remote_fault,
  output logic [`NUM_LANES-1:0][`LANE_IDX_W-1:0] pcs_lane_phys_index,
  output align_status_pkg::lane_vec_t pcs_lane_word_locked,
  // interrupt
  output logic irq
);
  import align_status_pkg::*;

  top_s s_reg;
  top_s s_next;

  lane_vec_t lane_seen;
  lane_vec_t lane_err;
  lane_vec_t lane_mism;
  logic [`NUM_LANES-1:0][`LANE_IDX_W-1:0] lane_id;
  logic acc;
  logic wr;
  logic addr_hit;
  logic rearm;
  logic marker_fault;
  logic err_event;
  logic timer_busy;
  logic timer_pulse;
  logic [`INT_W-1:0] int_set;
  logic [`INT_W-1:0] int_clr;

  // ----------------------------------------
  // per-lane checkers
  // ----------------------------------------
  for (genvar gi = 0; gi < `NUM_LANES; gi++)
  begin : g_lane
    lane_marker_check u_check
    (
      .clock(clock),
      .rst(rst),
      .word_sync(word_sync[gi]),
      .marker_strobe(marker_strobe[gi]),
      .marker_ok(marker_ok[gi]),
      .marker_id(marker_id[gi]),
      .seen(lane_seen[gi]),
      .id(lane_id[gi]),
      .err(lane_err[gi]),
      .mism(lane_mism[gi])
    );
  end

  // ----------------------------------------
  // metaframe delay
  // ----------------------------------------
  misalign_timer u_timer
  (
    .clock(clock),
    .rst(rst),
    .clear(rearm),
    .err_event(err_event),
    .mf_len_minus1(s_reg.mf_len),
    .busy(timer_busy),
    .pulse(timer_pulse)
  );

  // ----------------------------------------
  // bus decode and events
  // ----------------------------------------
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign addr_hit = paddr inside {`OFF_CTRL, `OFF_MF_LEN, `OFF_STATUS, `OFF_LOCKED,
                                  `OFF_INT_STAT, `OFF_INT_MASK, `OFF_MIS_CNT};
  assign rearm = wr & (paddr == `OFF_CTRL) & pwdata[`CTRL_REARM];
  assign marker_fault = (|lane_err) | (|lane_mism);
  assign err_event = (s_reg.align == ALIGN_ARMED) & s_reg.check_en & marker_fault;

  assign int_set[`INT_MISALIGN] = timer_pulse;
  assign int_set[`INT_WORD_ERR] = |lane_err;
  assign int_set[`INT_REMOTE] = remote_fault_in & ~s_reg.rf;
  assign int_set[`INT_ARMED] = (s_reg.align == ALIGN_WAIT) & (s_next.align == ALIGN_ARMED);
  assign int_clr = (wr && paddr == `OFF_INT_STAT) ? pwdata[`INT_W-1:0] : '0;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    s_next = s_reg;
    s_next.rf = remote_fault_in;
    // lane map from the per-lane captured ids
    for (int p = 0; p < `NUM_LANES; p++)
    begin
      s_next.locked[p] = 1'b0;
      s_next.phys[p] = '0;
      for (int i = 0; i < `NUM_LANES; i++)
      begin
        if (lane_seen[i] && word_sync[i] && lane_id[i] == lane_idx_t'(p))
        begin
          s_next.locked[p] = 1'b1;
          s_next.phys[p] = lane_idx_t'(i);
        end
      end
    end
    // arming once every logical lane is locked and checking is enabled
    unique case (s_reg.align)
      ALIGN_WAIT:
      begin
        if (s_reg.check_en && &s_reg.locked)
          s_next.align = ALIGN_ARMED;
      end
      ALIGN_ARMED:
      begin
        if (rearm)
          s_next.align = ALIGN_WAIT;
      end
      default:
        s_next.align = ALIGN_WAIT;
    endcase
    // misalignment event count
    if (rearm)
      s_next.mis_cnt = '0;
    else if (timer_pulse && s_reg.mis_cnt != '1)
      s_next.mis_cnt = s_reg.mis_cnt + 1'b1;
    // sticky status, set wins over clear
    s_next.int_stat = (s_reg.int_stat & ~int_clr) | int_set;
    // register writes
    if (wr)
    begin
      case (paddr)
        `OFF_CTRL:
          s_next.check_en = pwdata[`CTRL_CHECK_EN];
        `OFF_MF_LEN:
          s_next.mf_len = pwdata[`MF_LEN_W-1:0];
        `OFF_INT_MASK:
          s_next.int_mask = pwdata[`INT_W-1:0];
        default:
          s_next.check_en = s_reg.check_en;
      endcase
    end
    // read data captured in the setup phase
    if (psel && !penable && !pwrite)
    begin
      s_next.prdata = '0;
      case (paddr)
        `OFF_CTRL:
          s_next.prdata[`CTRL_CHECK_EN] = s_reg.check_en;
        `OFF_MF_LEN:
          s_next.prdata[`MF_LEN_W-1:0] = s_reg.mf_len;
        `OFF_STATUS:
        begin
          s_next.prdata[`STAT_ARMED] = (s_reg.align == ALIGN_ARMED);
          s_next.prdata[`STAT_REMOTE] = s_reg.rf;
          s_next.prdata[`STAT_ALL_LOCKED] = &s_reg.locked;
        end
        `OFF_LOCKED:
          s_next.prdata[`NUM_LANES-1:0] = s_reg.locked;
        `OFF_INT_STAT:
          s_next.prdata[`INT_W-1:0] = s_reg.int_stat;
        `OFF_INT_MASK:
          s_next.prdata[`INT_W-1:0] = s_reg.int_mask;
        `OFF_MIS_CNT:
          s_next.prdata[`CNT_W-1:0] = s_reg.mis_cnt;
        default:
          s_next.prdata = '0;
      endcase
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
      s_reg <= '{align: ALIGN_WAIT, check_en: `CTRL_RESET, mf_len: MF_LEN_MINUS1,
                 default: '0};
    else
      s_reg <= s_next;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prdata = s_reg.prdata;
  assign pready = acc;
  assign pslverr = acc & ~addr_hit;
  assign lane_misalign_pulse = timer_pulse;
  assign lane_marker_word_error = lane_err;
  assign remote_fault = s_reg.rf;
  assign pcs_lane_phys_index = s_reg.phys;
  assign pcs_lane_word_locked = s_reg.locked;
  assign irq = |(s_reg.int_stat & s_reg.int_mask);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  lane_vec_t sync_seen_q;

  always_ff @(posedge clock)
  begin
    sync_seen_q <= lane_seen & word_sync;
  end

  sequence all_locked_s;
    s_reg.check_en && &s_reg.locked && s_reg.align == ALIGN_WAIT && !rearm;
  endsequence

  sequence armed_s;
    s_reg.align == ALIGN_ARMED;
  endsequence

  sequence fault_while_armed_s;
    armed_s and (s_reg.check_en && marker_fault && !timer_busy && !rearm);
  endsequence

  arm_after_lock_a: assert property (all_locked_s |=> armed_s)
    else $error("all lanes locked but not armed");
  fault_starts_wait_a: assert property (fault_while_armed_s |=>
    timer_busy || lane_misalign_pulse)
    else $error("marker fault while armed did not start wait");
  never_unarmed_a: assert property (s_reg.align == ALIGN_WAIT |-> !lane_misalign_pulse)
    else $error("misalign pulse before markers seen");
  rf_level_a: assert property (remote_fault_in ##1 remote_fault_in |-> remote_fault)
    else $error("remote fault not held high");
  rf_clear_a: assert property (!remote_fault_in ##1 !remote_fault_in |-> !remote_fault)
    else $error("remote fault high without cause");
  word_err_a: assert property ($rose(lane_marker_word_error[0]) |-> $past(marker_strobe[0]))
    else $error("word error without a marker");
  reset_zero_a: assert property (@(posedge clock) disable iff (1'b0)
    rst |=> !lane_misalign_pulse && !remote_fault && pcs_lane_phys_index == '0)
    else $error("outputs not zero after reset");
  no_early_arm_a: assert property (s_reg.align == ALIGN_WAIT && !(&s_reg.locked) |=>
    s_reg.align == ALIGN_WAIT)
    else $error("armed before all lanes locked");

  sequence misalign_seen_s;
    lane_misalign_pulse;
  endsequence

  sequence remote_rise_s;
    $rose(remote_fault);
  endsequence

  misalign_sticky_a: assert property (misalign_seen_s |=> s_reg.int_stat[`INT_MISALIGN])
    else $error("misalign pulse not kept in status");
  remote_sticky_a: assert property (remote_rise_s |-> s_reg.int_stat[`INT_REMOTE])
    else $error("remote fault rise not kept in status");

  for (genvar gp = 0; gp < `NUM_LANES; gp++)
  begin : g_map_chk
    locked_map_a: assert property (pcs_lane_word_locked[gp] |->
      sync_seen_q[pcs_lane_phys_index[gp]])
      else $error("locked lane maps to unsynced lane");
    index_steady_a: assert property (pcs_lane_word_locked[gp] && $stable(lane_id) &&
      $stable(lane_seen & word_sync) ##1 pcs_lane_word_locked[gp]
      |-> $stable(pcs_lane_phys_index[gp]))
      else $error("lane index moved without remap");
    lane_word_err_a: assert property (lane_marker_word_error[gp] |->
      $past(marker_strobe[gp] && !marker_ok[gp]))
      else $error("word error flag without malformed marker");
  end

  // ----------------------------------------
  // metaframe delay check
  // ----------------------------------------
  logic wait_on;
  logic [`MF_LEN_W-1:0] wait_cnt;
  logic [`MF_LEN_W-1:0] wait_len;

  always_ff @(posedge clock)
  begin
    if (rst || rearm)
    begin
      wait_on <= 1'b0;
      wait_cnt <= '0;
      wait_len <= '0;
    end
    else if (err_event && !timer_busy)
    begin
      wait_on <= 1'b1;
      wait_cnt <= '0;
      wait_len <= s_reg.mf_len;
    end
    else if (lane_misalign_pulse)
      wait_on <= 1'b0;
    else if (wait_on)
      wait_cnt <= wait_cnt + 1'b1;
  end

  sequence wait_done_s;
    wait_on && wait_cnt == wait_len;
  endsequence

  delay_exact_a: assert property (wait_on && lane_misalign_pulse |-> wait_cnt == wait_len)
    else $error("misalign pulse not one metaframe after error");
  delay_due_a: assert property (wait_done_s |-> lane_misalign_pulse)
    else $error("no misalign pulse one metaframe after error");
endmodule

// ==== verif/link_status_monitor.sv ====
// user-side model: counts misalign pulses, reads one lane index when valid
// assumes status outputs arrive on the same clock as the block
`timescale 1ns/1ps
`include "align_status_regs.svh"
module link_status_monitor
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // status from the block
  input wire logic lane_misalign_pulse,
  input wire align_status_pkg::lane_vec_t pcs_lane_word_locked,
  input wire logic [`NUM_LANES-1:0][`LANE_IDX_W-1:0] pcs_lane_phys_index,
  input wire align_status_pkg::lane_idx_t sel,
  // user view
  output logic [15:0] misalign_cnt,
  output align_status_pkg::lane_idx_t sel_index,
  output logic sel_valid
);
  import align_status_pkg::*;
  // ----------------------------------------
  // counting and gating
  // ----------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
      misalign_cnt <= 16'h0000;
    else if (lane_misalign_pulse)
      misalign_cnt <= misalign_cnt + 16'h0001;
  end
  assign sel_valid = pcs_lane_word_locked[sel];
  assign sel_index = sel_valid ? pcs_lane_phys_index[sel] : 5'h1f;
endmodule

// ==== verif/lane_align_status_tb.sv ====
// self-checking bench for the lane alignment status block
// assumes the package, header and user-side monitor are compiled first
`timescale 1ns/1ps
`include "align_status_regs.svh"
module lane_align_status_tb;
  import align_status_pkg::*;
  localparam logic [15:0] MF = 16'h0008;
  logic clock, rst, psel, penable, pwrite, pready, pslverr, remote_fault_in;
  logic lane_misalign_pulse, remote_fault, irq, sel_valid, rf_d;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  lane_vec_t word_sync, marker_strobe, marker_ok, lane_marker_word_error;
  lane_vec_t pcs_lane_word_locked, we_d;
  logic [19:0][4:0] marker_id, pcs_lane_phys_index;
  lane_idx_t sel, sel_index;
  logic [15:0] misalign_cnt;
  logic [32:0] q_rd[$];
  int q_pulse[$];
  int cyc, error_cnt, n_compared, seed, k, base;
  // ----------------------------------------
  // clock, design and user-side model
  // ----------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  lane_align_status #(.MF_LEN_MINUS1(MF)) uut (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .word_sync(word_sync), .marker_strobe(marker_strobe),
    .marker_ok(marker_ok), .marker_id(marker_id), .remote_fault_in(remote_fault_in),
    .lane_misalign_pulse(lane_misalign_pulse), .lane_marker_word_error(lane_marker_word_error),
    .remote_fault(remote_fault), .pcs_lane_phys_index(pcs_lane_phys_index),
    .pcs_lane_word_locked(pcs_lane_word_locked), .irq(irq));
  link_status_monitor mon (.clock(clock), .rst(rst), .lane_misalign_pulse(lane_misalign_pulse),
    .pcs_lane_word_locked(pcs_lane_word_locked), .pcs_lane_phys_index(pcs_lane_phys_index),
    .sel(sel), .misalign_cnt(misalign_cnt), .sel_index(sel_index), .sel_valid(sel_valid));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
    input logic [32:0] e);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    if (!wr)
      q_rd.push_back(e);
    @(posedge clock);
    penable <= 1'b1;
    do
      @(posedge clock);
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic strobe(input lane_vec_t s, input lane_vec_t ok, input int n, input int ev);
    @(posedge clock);
    base = cyc;
    marker_strobe <= s;
    marker_ok <= ok;
    for (int i = 0; i < n; i++)
      if (ev)
        q_pulse.push_back(base + MF + 3 + i);
    repeat (n) @(posedge clock);
    marker_strobe <= '0;
  endtask
  function automatic lane_idx_t pl(input int i);
    return lane_idx_t'((i + k) % 20);
  endfunction
  // ----------------------------------------
  // output watcher
  // ----------------------------------------
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc > 3000)
    begin
      error_cnt++;
      end_of_test();
    end
    if (psel && penable && !pwrite && pready)
      cmp({pslverr, prdata}, q_rd.pop_front());
    if (lane_misalign_pulse !== 1'b0)
      cmp(cyc, (q_pulse.size() > 0) ? q_pulse.pop_front() : 0);
    if (cyc > 1)
    begin
      cmp(lane_marker_word_error, we_d);
      cmp(remote_fault, rf_d);
    end
    we_d <= rst ? '0 : marker_strobe & ~marker_ok;
    rf_d <= rst ? 1'b0 : remote_fault_in;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    seed = 59;
    {rst, psel, penable, pwrite, remote_fault_in, rf_d} = 6'h20;
    {paddr, pwdata, word_sync, marker_strobe, marker_ok, marker_id, we_d} = '0;
    {sel, cyc, error_cnt, n_compared} = '0;
    repeat (5) @(posedge clock);
    cmp({|pcs_lane_phys_index, lane_misalign_pulse, remote_fault, sel_valid}, 0);
    rst <= 1'b0;
    apb(1'b0, `OFF_CTRL, '0, 33'h1);
    apb(1'b0, `OFF_MF_LEN, '0, {17'h0, MF});
    apb(1'b0, 12'h01c, '0, 33'h1_0000_0000);
    strobe(20'h00020, '0, 1, 0);
    k = {$random(seed)} % 20;
    for (int i = 0; i < 20; i++)
      marker_id[i] <= pl(i);
    word_sync <= 20'hffffe;
    strobe('1, '1, 1, 0);
    repeat (4) @(posedge clock);
    cmp(pcs_lane_word_locked, lane_vec_t'(~(20'h1 << k)));
    apb(1'b0, `OFF_STATUS, '0, 33'h0);
    word_sync <= '1;
    strobe('1, '1, 1, 0);
    sel <= pl(3);
    repeat (4) @(posedge clock);
    cmp(pcs_lane_word_locked, 20'hfffff);
    for (int i = 0; i < 20; i++)
      cmp(pcs_lane_phys_index[pl(i)], i);
    cmp({sel_valid, sel_index}, 6'h23);
    apb(1'b0, `OFF_STATUS, '0, 33'h5);
    apb(1'b1, `OFF_INT_STAT, 32'hf, '0);
    apb(1'b1, `OFF_INT_MASK, 32'h1, '0);
    strobe(20'h00008, '0, 2, 1);
    repeat (20) @(posedge clock);
    cmp(irq, 1'b1);
    apb(1'b0, `OFF_INT_STAT, '0, 33'h3);
    apb(1'b1, `OFF_INT_STAT, 32'h1, '0);
    @(posedge clock);
    cmp(irq, 1'b0);
    marker_id[7] <= pl(8);
    strobe(20'h00080, 20'h00080, 1, 1);
    repeat (15) @(posedge clock);
    marker_id[7] <= pl(7);
    strobe(20'h00080, 20'h00080, 1, 1);
    repeat (15) @(posedge clock);
    cmp(pcs_lane_phys_index[pl(7)], 7);
    apb(1'b1, `OFF_CTRL, 32'h0, '0);
    strobe(20'h00008, '0, 1, 0);
    repeat (15) @(posedge clock);
    apb(1'b0, `OFF_MIS_CNT, '0, 33'h4);
    cmp(misalign_cnt, 4);
    cmp(q_pulse.size(), 0);
    apb(1'b1, `OFF_CTRL, 32'h3, '0);
    apb(1'b0, `OFF_MIS_CNT, '0, 33'h0);
    apb(1'b1, `OFF_INT_MASK, 32'h4, '0);
    repeat (30)
    begin
      @(posedge clock);
      remote_fault_in <= 1'($random(seed));
    end
    remote_fault_in <= 1'b0;
    @(posedge clock);
    remote_fault_in <= 1'b1;
    repeat (3) @(posedge clock);
    cmp(irq, 1'b1);
    apb(1'b1, `OFF_INT_STAT, 32'h4, '0);
    @(posedge clock);
    cmp(irq, 1'b0);
    repeat (3) @(posedge clock);
    end_of_test();
  end
endmodule
